// ==== verilog/vwfb_top.sv ====
// vector-write frame buffer: three colour planes, raster scan, vector write port
`timescale 1ns/1ps
`include "vwfb_params.svh"

// Functional notes
// R1: a full screen image is held in three one-bit colour planes, every bit addressable.
// R2: separate read and write counter sets each reach all three planes in parallel.
// R3: the read counters also produce horizontal and vertical timing.
// R4: the write counters load an 8-bit x and an 8-bit y coordinate in parallel.
// R5: the write counters step up or down on command along a vector.
// R6: every load or step of the write address stores the current colour at the new pixel.
// R7: asynchronous write requests are interleaved with raster reads without collision.
// R8: wait is high until each pixel write is done and the processor holds off meanwhile.
// R9: the image is 256 by 256 addressed directly by the two write coordinates.
// R10: pixel memory is write-only from the processor side.
// R11: the processor presents an 8-bit data byte and a 4-bit control address per write.
// R12: video timing is delivered to the processor input port for drawing sync.
// R13: the continuous raster reads of every row stand in for memory refresh.
// R14: the control address selects load x, load y, load colour, or step x/y up/down.
module vwfb_top import vwfb_pkg::*; #(
  parameter int H_TOTAL = `VWFB_H_TOTAL,
  parameter int V_TOTAL = `VWFB_V_TOTAL
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // processor write port (asynchronous)
  input  wire logic [7:0]   video_data_out_port,
  input  wire logic [3:0]   video_control_out_port,
  input  wire logic         wr_strobe,
  output logic              wr_wait,
  // timing back to processor
  output vwfb_timing_t      video_timing_in_port,
  // monitor
  output vwfb_pix_t         pix_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]   strb_sync;
    logic         strb_filt;
    logic [7:0]   dat_s0;
    logic [7:0]   dat_s1;
    logic [7:0]   dat_s2;
    logic [7:0]   dat_f;
    logic [3:0]   ctl_s0;
    logic [3:0]   ctl_s1;
    logic [3:0]   ctl_s2;
    logic [3:0]   ctl_f;
    logic         phase;
    logic [8:0]   hc;
    logic [8:0]   vc;
    logic [7:0]   wx;
    logic [7:0]   wy;
    vwfb_pix_t    col;
    vwfb_state_t  st;
    logic         wait_f;
    vwfb_timing_t tim;
  } vwfb_reg_t;

  vwfb_reg_t s_q;
  vwfb_reg_t s_d;
  vwfb_pix_t mem [0:65535];
  vwfb_pix_t pix_q;
  logic      strb_edge;
  logic      wr_slot;
  logic      active;

  logic [7:0] dat_in;
  logic [3:0] ctl_in;

  function automatic logic in_range(input logic [8:0] c, input int b, input int e);
    return (c >= 9'(b)) && (c < 9'(e));
  endfunction

  assign strb_edge = s_q.strb_sync[2] == s_q.strb_sync[1] && s_q.strb_sync[2] && !s_q.strb_filt;
  assign wr_slot   = (s_q.st == VWFB_WRITE) && s_q.phase; // [R7]
  assign active    = (s_q.hc < 9'(`VWFB_ACTIVE)) && (s_q.vc < 9'(`VWFB_ACTIVE));
  // agreed data and command after the pin synchronisers
  assign dat_in    = (s_q.dat_s2 == s_q.dat_s1) ? s_q.dat_s2 : s_q.dat_f;
  assign ctl_in    = (s_q.ctl_s2 == s_q.ctl_s1) ? s_q.ctl_s2 : s_q.ctl_f;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.strb_sync = {s_q.strb_sync[1:0], wr_strobe};
    if (s_q.strb_sync[2] == s_q.strb_sync[1]) begin
      s_d.strb_filt = s_q.strb_sync[2];
    end
    // data and command pin synchronisers [R7]
    s_d.dat_s0 = video_data_out_port;
    s_d.dat_s1 = s_q.dat_s0;
    s_d.dat_s2 = s_q.dat_s1;
    s_d.ctl_s0 = video_control_out_port;
    s_d.ctl_s1 = s_q.ctl_s0;
    s_d.ctl_s2 = s_q.ctl_s1;
    if (s_q.dat_s2 == s_q.dat_s1) begin
      s_d.dat_f = s_q.dat_s2;
    end
    if (s_q.ctl_s2 == s_q.ctl_s1) begin
      s_d.ctl_f = s_q.ctl_s2;
    end
    s_d.phase = ~s_q.phase;
    // read counters and timing
    if (s_q.phase) begin // [R3]
      if (s_q.hc == 9'(H_TOTAL - 1)) begin
        s_d.hc = 9'h000;
        s_d.vc = (s_q.vc == 9'(V_TOTAL - 1)) ? 9'h000 : s_q.vc + 9'h001;
      end else begin
        s_d.hc = s_q.hc + 9'h001;
      end
    end
    s_d.tim.hsync  = in_range(s_q.hc, `VWFB_H_SYNC_BEG, `VWFB_H_SYNC_END); // [R3] [R12]
    s_d.tim.vsync  = in_range(s_q.vc, `VWFB_V_SYNC_BEG, `VWFB_V_SYNC_END); // [R3] [R12]
    s_d.tim.hblank = s_q.hc >= 9'(`VWFB_ACTIVE);
    s_d.tim.vblank = s_q.vc >= 9'(`VWFB_ACTIVE);
    // write command decode
    if (wr_slot) begin
      s_d.st     = VWFB_IDLE;
      s_d.wait_f = 1'b0; // [R8]
    end
    if (strb_edge && s_q.st == VWFB_IDLE) begin
      s_d.st     = VWFB_WRITE; // [R6]
      s_d.wait_f = 1'b1; // [R8]
      unique case (ctl_in) // [R14]
        `VWFB_CMD_LD_X:   s_d.wx = dat_in; // [R4] [R9]
        `VWFB_CMD_LD_Y:   s_d.wy = dat_in; // [R4] [R9]
        `VWFB_CMD_X_UP:   s_d.wx = s_q.wx + 8'h01; // [R5]
        `VWFB_CMD_X_DN:   s_d.wx = s_q.wx - 8'h01; // [R5]
        `VWFB_CMD_Y_UP:   s_d.wy = s_q.wy + 8'h01; // [R5]
        `VWFB_CMD_Y_DN:   s_d.wy = s_q.wy - 8'h01; // [R5]
        `VWFB_CMD_LD_COL: begin
          s_d.col.r  = dat_in[`VWFB_COL_R_BIT];
          s_d.col.g  = dat_in[`VWFB_COL_G_BIT];
          s_d.col.b  = dat_in[`VWFB_COL_B_BIT];
          s_d.st     = VWFB_IDLE;
          s_d.wait_f = 1'b0;
        end
        default: begin
          s_d.st     = VWFB_IDLE;
          s_d.wait_f = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '{strb_sync: 3'h0, strb_filt: 1'b0, phase: 1'b0, hc: 9'h000, vc: 9'h000,
               wx: `VWFB_RST_COORD, wy: `VWFB_RST_COORD, col: '0, st: VWFB_IDLE,
               wait_f: 1'b0, tim: '0, dat_s0: 8'h00, dat_s1: 8'h00, dat_s2: 8'h00,
               dat_f: 8'h00, ctl_s0: 4'h0, ctl_s1: 4'h0, ctl_s2: 4'h0, ctl_f: 4'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // colour planes: reads on phase 0, writes on phase 1
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr_slot) begin
      mem[{s_q.wy, s_q.wx}] <= s_q.col; // [R1] [R2] [R6] [R10]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_q <= '0;
    end else if (!s_q.phase) begin
      pix_q <= active ? mem[{s_q.vc[7:0], s_q.hc[7:0]}] : '0; // [R2] [R13]
    end
  end

  assign wr_wait              = s_q.wait_f;
  assign video_timing_in_port = s_q.tim;
  assign pix_out              = pix_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_wait_set;
    strb_edge && s_q.st == VWFB_IDLE && ctl_in <= 4'h6
      && ctl_in != 4'h2 |=> wr_wait;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait not raised"); // [R8]
  property p_wait_bound;
    wr_wait |-> ##[1:2] !wr_wait;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("wait held too long"); // [R8]
  property p_ld_x;
    strb_edge && s_q.st == VWFB_IDLE && ctl_in == 4'h0
      |=> s_q.wx == $past(dat_in);
  endproperty
  a_ld_x: assert property (p_ld_x) else $error("x load wrong"); // [R4]
  property p_step_y;
    strb_edge && s_q.st == VWFB_IDLE && ctl_in == 4'h6
      |=> s_q.wy == $past(s_q.wy) - 8'h01;
  endproperty
  a_step_y: assert property (p_step_y) else $error("y step wrong"); // [R5]
  property p_write_follows;
    $rose(s_q.st == VWFB_WRITE) |-> ##[0:1] wr_slot;
  endproperty
  a_write_follows: assert property (p_write_follows) else $error("write missed"); // [R6]
  property p_slot_phase;
    wr_slot |=> !s_q.phase && s_q.st == VWFB_IDLE && !wr_wait;
  endproperty
  a_slot_phase: assert property (p_slot_phase) else $error("write in read slot"); // [R7]
  property p_col_nowait;
    strb_edge && s_q.st == VWFB_IDLE && ctl_in == 4'h2
      |=> !wr_wait && s_q.col == vwfb_pix_t'($past(dat_in[2:0]));
  endproperty
  a_col_nowait: assert property (p_col_nowait) else $error("colour load wrong"); // [R14]
  property p_hwrap;
    s_q.phase && s_q.hc == 9'(H_TOTAL - 1) |=> s_q.hc == 9'h000;
  endproperty
  a_hwrap: assert property (p_hwrap) else $error("line wrap wrong"); // [R3]
  property p_hsync;
    s_q.hc == 9'(`VWFB_H_SYNC_BEG) |=> video_timing_in_port.hsync;
  endproperty
  a_hsync: assert property (p_hsync) else $error("hsync missing"); // [R12]
  property p_blank_black;
    s_q.hc == 9'(`VWFB_ACTIVE) && !s_q.phase |=> pix_out == '0;
  endproperty
  a_blank_black: assert property (p_blank_black) else $error("pixel in blank"); // [R9]

  c_load: cover property (strb_edge && video_control_out_port == 4'h0);
  c_step: cover property (strb_edge && video_control_out_port == 4'h3);
  c_frame: cover property (s_q.vc == 9'(V_TOTAL - 1) && s_q.hc == 9'(H_TOTAL - 1));
  c_write: cover property (wr_slot);
endmodule

// ==== verilog/vwfb_params.svh ====
// constants for the vector-write frame buffer
`ifndef VWFB_PARAMS_SVH
`define VWFB_PARAMS_SVH
// ------------------------------------------------------------
// raster geometry (pixel clock = clk_sys / 2)
// ------------------------------------------------------------
`define VWFB_ACTIVE      256
`define VWFB_H_TOTAL     320
`define VWFB_H_SYNC_BEG  272
`define VWFB_H_SYNC_END  296
`define VWFB_V_TOTAL     280
`define VWFB_V_SYNC_BEG  264
`define VWFB_V_SYNC_END  268
// ------------------------------------------------------------
// control address codes
// ------------------------------------------------------------
`define VWFB_CMD_LD_X    4'h0
`define VWFB_CMD_LD_Y    4'h1
`define VWFB_CMD_LD_COL  4'h2
`define VWFB_CMD_X_UP    4'h3
`define VWFB_CMD_X_DN    4'h4
`define VWFB_CMD_Y_UP    4'h5
`define VWFB_CMD_Y_DN    4'h6
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define VWFB_COL_R_BIT   2
`define VWFB_COL_G_BIT   1
`define VWFB_COL_B_BIT   0
`define VWFB_RST_COORD   8'h00
`endif

// ==== verilog/vwfb_pkg.sv ====
// types for the vector-write frame buffer
package vwfb_pkg;
  typedef enum logic {VWFB_IDLE = 1'b0, VWFB_WRITE = 1'b1} vwfb_state_t;
  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } vwfb_pix_t;
  typedef struct packed {
    logic vblank;
    logic hblank;
    logic vsync;
    logic hsync;
  } vwfb_timing_t;
endpackage

// ==== verif/vwfb_cpu_model.sv ====
// game processor model driving the vector write port
`timescale 1ns/1ps
module vwfb_cpu_model (
  // clock
  input  wire logic       clk_sys,
  // write port
  input  wire logic       wr_wait,
  output logic [7:0]      video_data_out_port,
  output logic [3:0]      video_control_out_port,
  output logic            wr_strobe
);
  initial begin
    video_data_out_port    = 8'h00;
    video_control_out_port = 4'h0;
    wr_strobe              = 1'b0;
  end
  // ----------------------------------------
  // one write, reports whether wait was seen
  // ----------------------------------------
  task automatic xfer(input logic [3:0] cmd, input logic [7:0] dat, output logic got);
    int n;
    got = 1'b0;
    @(posedge clk_sys);
    video_control_out_port <= cmd;
    video_data_out_port    <= dat;
    wr_strobe              <= 1'b1;
    for (n = 0; n < 10 && !got; n++) begin
      @(posedge clk_sys);
      #1;
      got = (wr_wait === 1'b1);
    end
    for (n = 0; n < 10 && wr_wait !== 1'b0; n++) begin // hold off
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    wr_strobe              <= 1'b0;
    video_data_out_port    <= ~dat;
    video_control_out_port <= ~cmd;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// testbench for the vector-write frame buffer
`timescale 1ns/1ps
`include "vwfb_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top import vwfb_pkg::*;;
  localparam int HT = 300;
  localparam int VT = 270;
  logic         clk_sys;
  logic         rst;
  logic [7:0]   dat;
  logic [3:0]   ctl;
  logic         strb;
  logic         wr_wait;
  vwfb_timing_t tim;
  vwfb_pix_t    pix_out;
  vwfb_pix_t    seen [logic [15:0]];
  vwfb_pix_t    exp_pix [logic [15:0]];
  vwfb_pix_t    col;
  logic [7:0]   wx;
  logic [7:0]   wy;
  logic         got;
  int           ln;
  int           pc;
  int           n;
  logic         hb_q;
  int           n_errors = 0;
  int           tests_run = 0;
  vwfb_top #(.H_TOTAL(HT), .V_TOTAL(VT)) u_vwfb_top (.clk_sys(clk_sys), .rst(rst),
    .video_data_out_port(dat), .video_control_out_port(ctl), .wr_strobe(strb),
    .wr_wait(wr_wait), .video_timing_in_port(tim), .pix_out(pix_out));
  vwfb_cpu_model u_vwfb_cpu_model (.clk_sys(clk_sys), .wr_wait(wr_wait),
    .video_data_out_port(dat), .video_control_out_port(ctl), .wr_strobe(strb));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // raster capture of displayed pixels
  // ----------------------------------------
  always @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      ln = -1;
      pc = 0;
      hb_q = 1'b1;
    end else begin
      if (tim.vblank) ln = -1;
      else if (hb_q && !tim.hblank) begin
        ln++;
        pc = 0;
      end else pc++;
      if (pc[0] && ln >= 0 && ln < 256 && pc < 512) seen[{ln[7:0], pc[8:1]}] = pix_out;
      if (tim.hblank) `CHK(pix_out, vwfb_pix_t'(3'h0))
      if (!tim.vblank) `CHK(tim.vsync, 1'b0)
      hb_q = tim.hblank;
    end
  end
  task automatic wr(input logic [3:0] c, input logic [7:0] d);
    logic w;
    w = c inside {`VWFB_CMD_LD_X, `VWFB_CMD_LD_Y, `VWFB_CMD_X_UP,
                  `VWFB_CMD_X_DN, `VWFB_CMD_Y_UP, `VWFB_CMD_Y_DN};
    u_vwfb_cpu_model.xfer(c, d, got);
    case (c)
      `VWFB_CMD_LD_X:   wx = d;
      `VWFB_CMD_LD_Y:   wy = d;
      `VWFB_CMD_LD_COL: col = vwfb_pix_t'(d[2:0]);
      `VWFB_CMD_X_UP:   wx++;
      `VWFB_CMD_X_DN:   wx--;
      `VWFB_CMD_Y_UP:   wy++;
      `VWFB_CMD_Y_DN:   wy--;
      default: ;
    endcase
    if (w) exp_pix[{wy, wx}] = col;
    `CHK(got, w)
  endtask
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    wx = 8'h00;
    wy = 8'h00;
    col = vwfb_pix_t'(3'h0);
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wr(`VWFB_CMD_LD_COL, 8'h05);
    wr(`VWFB_CMD_LD_Y, 8'h14);
    wr(`VWFB_CMD_LD_X, 8'hFF);
    wr(`VWFB_CMD_X_UP, 8'h00);
    wr(`VWFB_CMD_LD_COL, 8'h03);
    wr(`VWFB_CMD_X_DN, 8'h00);
    wr(`VWFB_CMD_Y_UP, 8'h00);
    wr(`VWFB_CMD_Y_DN, 8'h00);
    for (int c = 7; c < 16; c++) wr(4'(c), 8'hA5);
    wr(`VWFB_CMD_X_UP, 8'h00);
    wr(`VWFB_CMD_LD_COL, 8'h06);
    wr(`VWFB_CMD_LD_Y, 8'h1E);
    wr(`VWFB_CMD_LD_X, 8'h0A);
    for (int i = 0; i < 8; i++) begin
      wr(`VWFB_CMD_X_UP, 8'h00);
      wr(`VWFB_CMD_Y_UP, 8'h00);
    end
    wait (ln == 48);
    foreach (exp_pix[k]) `CHK(seen[k], exp_pix[k])
    wait (tim.hsync === 1'b0);
    wait (tim.hsync === 1'b1);
    @(negedge clk_sys);
    n = 0;
    while (tim.hsync === 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n, 2 * (`VWFB_H_SYNC_END - `VWFB_H_SYNC_BEG))
    while (tim.hsync === 1'b0) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n, 2 * HT)
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end
endmodule
